// ### design/tcc_down_timer.sv
// one reloading down counter with latch
`timescale 1ns/100ps
`default_nettype none
module tcc_down_timer #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic pclk,    // system clock
  input wire logic presetn, // async reset, low
  tcc_tmr_if.tmr t          // control and status
);

  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  if (W < 2) begin : g_bad_w
    $error("timer width below two bits");
  end

  logic [W-1:0] latch; // reload value

  // underflow on the pulse after zero
  assign t.ovf = t.tick && !t.load && (t.count == '0);

  // latch follows every load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch <= RST_VAL;
    end else if (t.load) begin
      latch <= t.load_val;
    end
  end

  // counter: load wins, else count down and reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t.count <= RST_VAL;
    end else if (t.load) begin
      t.count <= t.load_val;
    end else if (t.tick) begin
      if (t.count == '0) begin
        t.count <= latch;
      end else begin
        t.count <= t.count - 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_load_sets_count: assert property (
    t.load |=> t.count == $past(t.load_val))
    else $error("load did not set counter");
  a_count_reload: assert property (
    t.tick && !t.load && t.count == '0 |=> t.count == $past(latch))
    else $error("counter did not reload from latch");

endmodule
`default_nettype wire

// ### design/tcc_pkg.sv
// shared constants and types for the timer chain block
package tcc_pkg;

  // ---------------------------------------------------------------
  // bus and register map
  // ---------------------------------------------------------------
  localparam int APB_AW = 12;                     // apb address width
  localparam logic [11:0] ADDR_LATCH0 = 12'h000;  // timer 1 latch
  localparam logic [11:0] ADDR_STRIDE = 12'h004;  // word stride
  localparam logic [11:0] ADDR_CTRL = 12'h018;    // extra control bits
  localparam logic [11:0] ADDR_REQ = 12'h01c;     // requests and state
  localparam logic [11:0] ADDR_MODE1 = 12'h0f4;   // timer_mode_one

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_MODE1 = 8'h00;       // all sources div16
  localparam logic [7:0] RST_T3 = 8'hff;          // timer 3 preload
  localparam logic [7:0] RST_T4 = 8'h07;          // timer 4 preload
  localparam logic [7:0] RST_LATCH = 8'h00;       // other timers
  localparam logic [4:0] RST_CTRL = 5'h00;        // extra control

  // ---------------------------------------------------------------
  // timer_mode_one fields
  // ---------------------------------------------------------------
  localparam int T1_SRC_SEL_A = 0;
  localparam int T2_SRC_SEL_A = 1;
  localparam int T1_HALT = 2;
  localparam int T2_HALT = 3;
  localparam int T2_SRC_SEL_B = 4;
  localparam int T1_SRC_SEL_B = 5;
  localparam int T5_SRC_SEL = 6;
  localparam int T6_SRC_SEL = 7;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int CTL_SUB_OSC = 0;      // sub_osc_select
  localparam int CTL_T3_ALT_A = 1;     // timer mode two bit 0
  localparam int CTL_T3_ALT_B = 2;     // port three direction bit 6
  localparam int CTL_PIN_SEL = 3;      // port three direction bit 7
  localparam int CTL_T5_CHAIN = 4;     // timer 5 counts an overflow

  // ---------------------------------------------------------------
  // request register fields and prescaler
  // ---------------------------------------------------------------
  localparam int REQ_RESET_HELD = 6;   // internal reset still held
  localparam int REQ_STOPPED = 7;      // internal stop state
  localparam int PRE_W = 12;           // divide by 4096
  localparam int DIV16_W = 4;          // divide by 16
  localparam int NUM_TMR = 6;          // timers 1 to 6

  // chain state, one-hot
  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_RUN = 3'b010,
    ST_STOP = 3'b100
  } tcc_state_t;

endpackage

// ### design/tcc_timer_chain.sv
// six 8-bit timers with oscillator wait chain and apb registers
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - mode bit 7: timer 6 div16 or t5
// - timer 5 prescales timer 6 when chained
// - timer 6 overflow raises its request
// - reset chains 3-4, loads ff/07, div16
// - internal reset held until timer 4 overflow
// - stop chains 3-4, loads ff/07, keeps source
// - stop state ends at timer 4 overflow
// - sub oscillator select replaces main oscillator
// - pin select bit routes external clock
// - mode bit 0: timer 1 div16 or bit5
// - mode bit 5: div4096 or external pin
// - mode bit 1: timer 2 bit4 or pin
// - mode bit 4: div16 or timer 1 overflow
// - mode bits 2,3 halt timers 1,2
// - mode bit 6: timer 5 from t2 or t4
// - down count, divide n+1, write loads
// - overflow after zero sets request bit
module tcc_timer_chain (
  input wire logic pclk,                  // system clock
  input wire logic presetn,               // async reset, low
  input wire logic [11:0] paddr,          // apb address
  input wire logic psel,                  // apb select
  input wire logic penable,               // apb enable
  input wire logic pwrite,                // apb direction
  input wire logic [31:0] pwdata,         // apb write data
  output logic [31:0] prdata,             // apb read data
  output logic pready,                    // apb ready
  output logic pslverr,                   // apb error
  input wire logic main_osc,              // main oscillator pin
  input wire logic sub_osc,               // sub oscillator pin
  input wire logic ext_timer_clk_pin_a,   // external clock, pin a
  input wire logic ext_timer_clk_pin_b,   // external clock, pin b
  input wire logic stop_instruction,      // stop executed, pulse
  output logic [5:0] timer_req,           // sticky overflow requests
  output logic internal_reset_n,          // internal reset, low
  output logic clock_connected            // internal clock running
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [7:0] timer_mode_one;             // mode register
  logic [4:0] ctrl;                       // extra control bits
  tcc_pkg::tcc_state_t state;             // chain state
  tcc_pkg::tcc_state_t next_state;        // next chain state
  logic [3:0] sync_a;                     // first sync stage
  logic [3:0] sync_b;                     // second sync stage
  logic [3:0] sync_c;                     // edge history
  logic [3:0] rise;                       // synced rising edges
  logic [tcc_pkg::PRE_W-1:0] pre;         // oscillator prescaler
  logic base_tick;                        // selected oscillator edge
  logic div16;                            // oscillator / 16
  logic div4096;                          // oscillator / 4096
  logic ext_tick;                         // external pin edge
  logic t3_src;                           // timer 3 chosen source
  logic chain;                            // timers 3 and 4 chained
  logic force_load;                       // preload timers 3 and 4
  logic [5:0] tick;                       // count pulses
  logic [5:0] load;                       // load strobes
  logic [7:0] load_val [6];               // load values
  logic [7:0] count [6];                  // counter values
  logic [5:0] ovf;                        // overflow pulses
  logic wr;                               // apb write strobe
  logic first;                            // first cycle after reset

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // latch index of an address, or 7 when not a latch
  function automatic logic [2:0] latch_idx(input logic [11:0] a);
    logic [2:0] r;
    r = 3'd7;
    for (int i = 0; i < tcc_pkg::NUM_TMR; i++) begin
      if (a == tcc_pkg::ADDR_LATCH0 + 12'(i) * tcc_pkg::ADDR_STRIDE) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // address decodes to a register
  function automatic logic mapped(input logic [11:0] a);
    return latch_idx(a) != 3'd7 || a == tcc_pkg::ADDR_CTRL ||
      a == tcc_pkg::ADDR_REQ || a == tcc_pkg::ADDR_MODE1;
  endfunction

  // ---------------------------------------------------------------
  // apb slave, no wait states
  // ---------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign wr = psel && penable && pwrite && mapped(paddr);

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
      if (latch_idx(paddr) != 3'd7) begin
        prdata[7:0] <= count[latch_idx(paddr)];
      end else if (paddr == tcc_pkg::ADDR_CTRL) begin
        prdata[4:0] <= ctrl;
      end else if (paddr == tcc_pkg::ADDR_REQ) begin
        prdata[5:0] <= timer_req;
        prdata[tcc_pkg::REQ_RESET_HELD] <= state == tcc_pkg::ST_WAIT;
        prdata[tcc_pkg::REQ_STOPPED] <= state == tcc_pkg::ST_STOP;
      end else if (paddr == tcc_pkg::ADDR_MODE1) begin
        prdata[7:0] <= timer_mode_one;
      end
    end
  end

  // mode register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode_one <= tcc_pkg::RST_MODE1;
    end else if (wr && paddr == tcc_pkg::ADDR_MODE1) begin
      timer_mode_one <= pwdata[7:0];
    end
  end

  // control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= tcc_pkg::RST_CTRL;
    end else if (wr && paddr == tcc_pkg::ADDR_CTRL) begin
      ctrl <= pwdata[4:0];
    end
  end

  // requests: overflow sets, writing zero clears, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_req <= 6'h00;
    end else begin
      for (int i = 0; i < tcc_pkg::NUM_TMR; i++) begin
        if (ovf[i]) begin
          timer_req[i] <= 1'b1;
        end else if (wr && paddr == tcc_pkg::ADDR_REQ && !pwdata[i]) begin
          timer_req[i] <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers and edge detect
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
      sync_c <= 4'h0;
    end else begin
      sync_a <= {ext_timer_clk_pin_b, ext_timer_clk_pin_a, sub_osc,
                 main_osc};
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end
  assign rise = sync_b & ~sync_c;

  // sub oscillator replaces main when selected
  assign base_tick = ctrl[tcc_pkg::CTL_SUB_OSC] ? rise[1] : rise[0];
  // pin select bit picks one of two pins
  assign ext_tick = ctrl[tcc_pkg::CTL_PIN_SEL] ? rise[3] : rise[2];

  // ---------------------------------------------------------------
  // oscillator prescaler
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre <= '0;
    end else if (base_tick) begin
      pre <= pre + 1'b1;
    end
  end
  assign div16 = base_tick && (&pre[tcc_pkg::DIV16_W-1:0]);
  assign div4096 = base_tick && (&pre);

  // ---------------------------------------------------------------
  // count source selection
  // ---------------------------------------------------------------
  assign chain = state != tcc_pkg::ST_RUN;
  // at reset div16 is forced; on stop the programmed source stays
  assign t3_src = (state == tcc_pkg::ST_WAIT) ? div16 :
    ((ctrl[tcc_pkg::CTL_T3_ALT_A] || ctrl[tcc_pkg::CTL_T3_ALT_B]) ?
     rise[1] : div16);

  always_comb begin
    // timer 1
    if (timer_mode_one[tcc_pkg::T1_HALT]) begin
      tick[0] = 1'b0;
    end else if (timer_mode_one[tcc_pkg::T1_SRC_SEL_A]) begin
      tick[0] = timer_mode_one[tcc_pkg::T1_SRC_SEL_B] ?
        ext_tick : div4096;
    end else begin
      tick[0] = div16;
    end
    // timer 2
    if (timer_mode_one[tcc_pkg::T2_HALT]) begin
      tick[1] = 1'b0;
    end else if (timer_mode_one[tcc_pkg::T2_SRC_SEL_A]) begin
      tick[1] = ext_tick;
    end else begin
      tick[1] = timer_mode_one[tcc_pkg::T2_SRC_SEL_B] ?
        ovf[0] : div16;
    end
    // timers 3 and 4: timer 3 overflow clocks timer 4 in the chain
    tick[2] = t3_src;
    tick[3] = chain ? ovf[2] : div16;
    // timer 5: chained overflow or div16
    if (ctrl[tcc_pkg::CTL_T5_CHAIN]) begin
      tick[4] = timer_mode_one[tcc_pkg::T5_SRC_SEL] ?
        ovf[3] : ovf[1];
    end else begin
      tick[4] = div16;
    end
    // timer 6: timer 5 acts as prescaler when chosen
    tick[5] = timer_mode_one[tcc_pkg::T6_SRC_SEL] ?
      ovf[4] : div16;
  end

  // ---------------------------------------------------------------
  // chain state machine
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      tcc_pkg::ST_WAIT: begin
        if (ovf[3]) begin
          next_state = tcc_pkg::ST_RUN;
        end
      end
      tcc_pkg::ST_RUN: begin
        if (stop_instruction) begin
          next_state = tcc_pkg::ST_STOP;
        end
      end
      tcc_pkg::ST_STOP: begin
        if (ovf[3]) begin
          next_state = tcc_pkg::ST_RUN;
        end
      end
      default: begin
        next_state = tcc_pkg::ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= tcc_pkg::ST_WAIT;
    end else begin
      state <= next_state;
    end
  end

  // flag for the first cycle after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first <= 1'b1;
    end else begin
      first <= 1'b0;
    end
  end

  assign internal_reset_n = state != tcc_pkg::ST_WAIT;
  assign clock_connected = state == tcc_pkg::ST_RUN;
  assign force_load = stop_instruction && state == tcc_pkg::ST_RUN;

  // ---------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------
  for (genvar g = 0; g < tcc_pkg::NUM_TMR; g++) begin : g_tmr
    localparam logic [7:0] RV = (g == 2) ? tcc_pkg::RST_T3 :
      (g == 3) ? tcc_pkg::RST_T4 : tcc_pkg::RST_LATCH;
    tcc_tmr_if #(.W(8)) u_if ();
    assign load[g] = (wr && latch_idx(paddr) == 3'(g)) ||
      (force_load && (g == 2 || g == 3));
    assign load_val[g] = (force_load && (g == 2 || g == 3)) ? RV :
      pwdata[7:0];
    assign u_if.tick = tick[g];
    assign u_if.load = load[g];
    assign u_if.load_val = load_val[g];
    assign count[g] = u_if.count;
    assign ovf[g] = u_if.ovf;
    tcc_down_timer #(.W(8), .RST_VAL(RV)) u_tmr (
      .pclk(pclk),
      .presetn(presetn),
      .t(u_if.tmr)
    );
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_t6_source: assert property (
    !timer_mode_one[tcc_pkg::T6_SRC_SEL] |-> tick[5] == div16)
    else $error("timer 6 not on div16");
  a_t5_prescale: assert property (
    timer_mode_one[tcc_pkg::T6_SRC_SEL] && ovf[4] |-> tick[5])
    else $error("timer 5 overflow did not clock timer 6");
  a_t6_request: assert property (
    ovf[5] |=> timer_req[5])
    else $error("timer 6 request not raised");
  a_reset_preload: assert property (
    first |-> count[2] == tcc_pkg::RST_T3 && count[3] == tcc_pkg::RST_T4
      && tick[2] == div16 && tick[3] == ovf[2])
    else $error("reset chain preload wrong");
  a_reset_hold: assert property (
    state == tcc_pkg::ST_WAIT && !ovf[3] |=> !internal_reset_n)
    else $error("internal reset released early");
  a_reset_release: assert property (
    state == tcc_pkg::ST_WAIT && ovf[3] |=> internal_reset_n)
    else $error("internal reset not released");
  a_stop_preload: assert property (
    force_load |=> count[2] == tcc_pkg::RST_T3 &&
      count[3] == tcc_pkg::RST_T4 && !clock_connected)
    else $error("stop preload wrong");
  a_stop_release: assert property (
    state == tcc_pkg::ST_STOP && ovf[3] |=> clock_connected)
    else $error("stop state not released");
  a_sub_osc: assert property (
    ctrl[tcc_pkg::CTL_SUB_OSC] && !rise[1] |=> $stable(pre))
    else $error("prescaler moved without a sub oscillator edge");
  a_t1_halt: assert property (
    timer_mode_one[tcc_pkg::T1_HALT] |=> count[0] == $past(count[0]) ||
      $past(load[0]))
    else $error("halted timer 1 moved");
  a_t2_from_t1: assert property (
    timer_mode_one[4:1] == 4'b1000 |-> tick[1] == ovf[0])
    else $error("timer 2 not on timer 1 overflow");
  a_chain_clock: assert property (
    chain |-> tick[3] == ovf[2])
    else $error("timer 4 not chained");
  a_mode_reset: assert property (
    first |-> timer_mode_one == tcc_pkg::RST_MODE1)
    else $error("mode register reset wrong");

  c_reset_release: cover property (
    state == tcc_pkg::ST_WAIT ##1 state == tcc_pkg::ST_RUN);
  c_stop_cycle: cover property (
    state == tcc_pkg::ST_STOP ##1 state == tcc_pkg::ST_RUN);
  c_t6_chain: cover property (
    timer_mode_one[tcc_pkg::T6_SRC_SEL] && ovf[5]);
  c_ext_count: cover property (ext_tick && tick[0]);

endmodule
`default_nettype wire

// ### design/tcc_tmr_if.sv
// carrier between the chain logic and one down counter
`timescale 1ns/100ps
`default_nettype none
interface tcc_tmr_if #(parameter int W = 8);
  logic tick;            // one count pulse
  logic load;            // load latch and counter
  logic [W-1:0] load_val; // value to load
  logic [W-1:0] count;   // counter value
  logic ovf;             // underflow pulse
  modport ctl (output tick, load, load_val, input count, ovf);
  modport tmr (input tick, load, load_val, output count, ovf);
endinterface
`default_nettype wire

// ### verif/tcc_timer_chain_bench.sv
// self-checking bench for the timer chain block
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_chain_bench;
  // ---------------------------------------------------------------
  // signals and design
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] mode;  // timer_mode_one value
    logic [4:0] ctrl;  // control value
    logic [47:0] lat;  // latches, timer 6 down to timer 1
    int b;             // request bit watched
    int p;             // expected period in cycles
  } tcc_case_t;
  logic pclk = 1'b0;                      // system clock
  logic presetn = 1'b0;                   // reset, low
  logic [11:0] paddr = '0;                // apb address
  logic psel = 1'b0, penable = 1'b0;      // apb controls
  logic pwrite = 1'b0;                    // apb direction
  logic [31:0] pwdata = '0, prdata;       // apb data
  logic pready, pslverr;                  // apb answer
  logic main_osc = 1'b0, sub_osc = 1'b0;  // oscillators
  logic ext_a = 1'b0, ext_b = 1'b0;       // external clock pins
  logic stop_instruction = 1'b0;          // stop pulse
  logic sub_run = 1'b1;                   // sub oscillator running
  logic [5:0] timer_req;                  // overflow requests
  logic internal_reset_n, clock_connected;
  int err_total = 0, n_checks = 0;        // report counters
  int cyc_now = 0, ph = 0, sph = 0;       // cycle stamp and phases
  tcc_case_t cases [9];                   // source and ratio table
  tcc_timer_chain uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_osc(main_osc), .sub_osc(sub_osc), .ext_timer_clk_pin_a(ext_a),
    .ext_timer_clk_pin_b(ext_b), .stop_instruction(stop_instruction),
    .timer_req(timer_req), .internal_reset_n(internal_reset_n),
    .clock_connected(clock_connected));
  // ---------------------------------------------------------------
  // clock and slow sources
  // ---------------------------------------------------------------
  always #5 pclk = ~pclk;
  // main and pin a period 8, pin b period 16, sub period 12 cycles
  always @(posedge pclk) begin
    cyc_now <= cyc_now + 1;
    ph <= ph + 1;
    main_osc <= ph[2];
    ext_a <= ph[2];
    ext_b <= ph[3];
    if (sub_run) begin
      sph <= (sph == 11) ? 0 : sph + 1;
      sub_osc <= (sph < 6);
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer: setup, then access until pready
  task automatic apb(input logic [11:0] a, input logic w,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      finish_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
    chk(r, x);
  endtask
  // wait for a request bit (0..5) or clock_connected (6), bounded
  task automatic wait_sig(input int s, input int lim, output int t);
    int n;
    for (n = 0; n < lim; n++) begin
      @(posedge pclk);
      if (((s < 6) ? timer_req[s] : clock_connected) === 1'b1) break;
    end
    if (n >= lim) begin
      err_total++;
      finish_test();
    end
    t = cyc_now;
  endtask
  // cycles between two successive sets of one request bit
  task automatic period(input int b, output int p);
    int t0, t1;
    wr(tcc_pkg::ADDR_REQ, 32'h0);
    wait_sig(b, 9000, t0);
    wr(tcc_pkg::ADDR_REQ, 32'h0);
    wait_sig(b, 9000, t1);
    p = t1 - t0;
  endtask
  task automatic stop_pulse();
    @(posedge pclk);
    stop_instruction <= 1'b1;
    @(posedge pclk);
    stop_instruction <= 1'b0;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int p, t0, t1;
    logic [31:0] r;
    logic e;
    cases[0] = '{8'h00, 5'h00, 48'hffffffffff02, 0, 384};
    cases[1] = '{8'h21, 5'h00, 48'hffffffffff03, 0, 32};
    cases[2] = '{8'h21, 5'h08, 48'hffffffffff03, 0, 64};
    cases[3] = '{8'h02, 5'h00, 48'hffffffff03ff, 1, 32};
    cases[4] = '{8'h10, 5'h00, 48'hffffffff0101, 1, 512};
    cases[5] = '{8'h80, 5'h10, 48'h0101ffff00ff, 5, 512};
    cases[6] = '{8'h00, 5'h00, 48'h00ffffffffff, 5, 128};
    cases[7] = '{8'h40, 5'h10, 48'hff0100ffffff, 4, 256};
    cases[8] = '{8'h00, 5'h01, 48'hffffffffff00, 0, 192};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(tcc_pkg::ADDR_MODE1, 32'h0);
    rd_chk(12'h008, 32'hff);
    rd_chk(12'h00c, 32'h07);
    rd_chk(tcc_pkg::ADDR_REQ, 32'h40);
    chk(internal_reset_n, 1'b0);
    apb(12'h100, 1'b0, 32'h0, r, e);
    chk(e, 1'b1);
    chk(r, 32'h0);
    // timer 3 reloads to zero, so timer 4 steps on every div16 tick
    wr(12'h008, 32'h0);
    t0 = cyc_now;
    wait_sig(6, 1500, t1);
    chk(t1 - t0 >= 7 * 128, 1'b1);
    chk(internal_reset_n, 1'b1);
    foreach (cases[i]) begin
      wr(tcc_pkg::ADDR_CTRL, {27'h0, cases[i].ctrl});
      wr(tcc_pkg::ADDR_MODE1, {24'h0, cases[i].mode});
      for (int k = 0; k < 6; k++) begin
        wr(12'(4 * k), {24'h0, cases[i].lat[8 * k +: 8]});
      end
      period(cases[i].b, p);
      chk(p, cases[i].p);
    end
    // both halt bits set with zero latches: no requests
    wr(tcc_pkg::ADDR_CTRL, 32'h0);
    wr(tcc_pkg::ADDR_MODE1, 32'h0c);
    wr(12'h000, 32'h0);
    wr(12'h004, 32'h0);
    wr(tcc_pkg::ADDR_REQ, 32'h0);
    repeat (400) @(posedge pclk);
    chk(timer_req[1:0], 2'b00);
    wr(tcc_pkg::ADDR_MODE1, 32'h0);
    // stop with timer 3 on a still sub oscillator
    wr(tcc_pkg::ADDR_CTRL, 32'h02);
    sub_run <= 1'b0;
    // let a last sub edge drain through the synchroniser first
    repeat (4) @(posedge pclk);
    stop_pulse();
    rd_chk(12'h008, 32'hff);
    rd_chk(12'h00c, 32'h07);
    chk(clock_connected, 1'b0);
    repeat (300) @(posedge pclk);
    rd_chk(12'h008, 32'hff);
    sub_run <= 1'b1;
    wait_sig(6, 30000, t1);
    apb(tcc_pkg::ADDR_REQ, 1'b0, 32'h0, r, e);
    chk(r[7:6], 2'b00);
    // software restores div16 before the next stop
    wr(tcc_pkg::ADDR_CTRL, 32'h0);
    stop_pulse();
    wr(12'h008, 32'h0);
    t0 = cyc_now;
    wait_sig(6, 1500, t1);
    chk(t1 - t0 >= 7 * 128, 1'b1);
    chk(internal_reset_n, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
